// *** verif/aad_datapath_chk.sv ***
// port checker for the accumulator add/abs datapath
`timescale 1ns/1ps
`default_nettype none
module aad_datapath_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire aad_pkg::aad_cmd_s cmd,
    input wire logic saturate_mode_bit,
    input wire logic [15:0] mem_rdata,
    input wire logic [31:0] acc,
    input wire logic carry_flag,
    input wire logic overflow_flag,
    input wire logic [15:0] instr_words,
    input wire logic done
);
    import aad_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic [32:0] hi_sum;
    logic is_abs;
    logic is_short;
    // carry of a shift-sixteen add, worked out beside the properties
    assign hi_sum = {1'b0, acc} + {1'b0, mem_rdata, 16'h0000};
    assign is_abs = cmd_valid && (cmd.op == AAD_OP_ABS);
    assign is_short = cmd_valid && (cmd.op == AAD_OP_ADD_SHORT);
    a_done_follows: assert property (cmd_valid |=> done)
        else $error("done missing after command");
    a_done_pulse: assert property (!cmd_valid |=> !done)
        else $error("done without command");
    a_abs_carry_clear: assert property (is_abs |=> !carry_flag)
        else $error("abs left carry set");
    a_abs_keeps_pos: assert property (is_abs && !acc[31] |=> acc == $past(acc))
        else $error("abs changed a non-negative value");
    a_abs_negates: assert property (
        is_abs && acc[31] && acc != AAD_ACC_MOST_NEG |=> acc == ~$past(acc) + 32'h0000_0001)
        else $error("abs did not negate");
    a_abs_most_neg: assert property (
        is_abs && acc == AAD_ACC_MOST_NEG |=> overflow_flag
        && acc == ($past(saturate_mode_bit) ? AAD_ACC_MOST_POS : AAD_ACC_MOST_NEG))
        else $error("abs of most negative value wrong");
    a_short_no_shift: assert property (
        is_short && !saturate_mode_bit |=> acc == $past(acc) + {24'h000000, $past(cmd.short_imm)})
        else $error("short add result wrong");
    a_hi_add_carry: assert property (
        cmd_valid && cmd.op == AAD_OP_ADD_MEM && cmd.shift16
        |=> carry_flag == ($past(carry_flag) || $past(hi_sum[32])))
        else $error("shift-sixteen add carry wrong");
    a_one_word: assert property (cmd_valid |=> instr_words == AAD_WORDS_ONE)
        else $error("add not one word");
    a_ov_sticky: assert property (overflow_flag |=> overflow_flag)
        else $error("overflow flag dropped");
    c_abs_most_neg: cover property (is_abs && acc == AAD_ACC_MOST_NEG);
    c_hi_carry: cover property (cmd_valid && cmd.shift16 && hi_sum[32]);
    c_post_inc: cover property (cmd_valid && cmd.indirect && cmd.post_inc);
endmodule // aad_datapath_chk
`default_nettype wire

// *** verif/test_aad_datapath.sv ***
// self-checking bench for the accumulator add/abs datapath
`timescale 1ns/1ps
`default_nettype none
module test_aad_datapath;
    import aad_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    aad_cmd_s cmd = '0;
    aad_cost_s cost = '0;
    logic sign_extend_mode_bit = 1'b0;
    logic saturate_mode_bit = 1'b0;
    logic [2:0] aux_init_sel = 3'h0;
    logic [15:0] aux_init_value = 16'h0000;
    logic aux_init_we = 1'b0;
    logic [15:0] mem_rdata = 16'h0000;
    logic ext_valid = 1'b0;
    logic ext_write = 1'b0;
    logic [15:0] ext_wait_states = 16'h0000;
    logic ext_next_is_read = 1'b0;
    logic [15:0] mem_addr, aux_register_four, instr_words, instr_cycles, ext_access_cycles;
    logic [31:0] acc;
    logic carry_flag, overflow_flag, sameblock_conflict, done;
    logic [2:0] aux_pointer_select;
    int err_total = 0;
    int samples_checked = 0;
    aad_datapath DUT (.core_clk, .rst_n, .cmd_valid, .cmd, .cost, .sign_extend_mode_bit,
        .saturate_mode_bit, .aux_init_sel, .aux_init_value, .aux_init_we, .mem_rdata,
        .ext_valid, .ext_write, .ext_wait_states, .ext_next_is_read, .mem_addr, .acc,
        .carry_flag, .overflow_flag, .aux_pointer_select, .aux_register_four, .instr_words,
        .instr_cycles, .sameblock_conflict, .ext_access_cycles, .done);
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rst();
        @(posedge core_clk) #1 rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic run(input aad_cmd_s c, input logic [15:0] d);
        @(posedge core_clk) #1 cmd = c;
        cmd_valid = 1'b1;
        mem_rdata = d;
        @(posedge core_clk) #1 cmd_valid = 1'b0;
        chk(done, 32'h1);
        chk(instr_words, 32'h1);
    endtask
    task automatic op(input aad_op_e o, input logic [15:0] d, input logic [3:0] sh,
                      input logic s16);
        aad_cmd_s c;
        c = '0;
        c.op = o;
        c.shift = sh;
        c.shift16 = s16;
        c.short_imm = d[7:0];
        run(c, d);
    endtask
    task automatic t_abs();
        rst();
        sign_extend_mode_bit = 1'b1;
        op(AAD_OP_ADD_MEM, 16'hFFFE, 4'h0, 1'b0);
        op(AAD_OP_ABS, 16'h0000, 4'h0, 1'b0);
        chk(acc, 32'h0000_0002);
        chk(carry_flag, 32'h0);
        // leave carry set so the clear below is seen
        op(AAD_OP_ADD_MEM, 16'hFFFF, 4'h0, 1'b0);
        chk({acc[30:0], carry_flag}, 32'h0000_0003);
        op(AAD_OP_ABS, 16'h0000, 4'h0, 1'b0);
        chk(acc, 32'h0000_0001);
        chk(carry_flag, 32'h0);
        rst();
        op(AAD_OP_ADD_MEM, 16'h8000, 4'h0, 1'b1);
        op(AAD_OP_ABS, 16'h0000, 4'h0, 1'b0);
        chk(acc, AAD_ACC_MOST_NEG);
        chk(overflow_flag, 32'h1);
        rst();
        op(AAD_OP_ADD_MEM, 16'h8000, 4'h0, 1'b1);
        saturate_mode_bit = 1'b1;
        op(AAD_OP_ABS, 16'h0000, 4'h0, 1'b0);
        chk(acc, AAD_ACC_MOST_POS);
        chk(overflow_flag, 32'h1);
    endtask
    task automatic t_carry();
        rst();
        saturate_mode_bit = 1'b0;
        op(AAD_OP_ADD_SHORT, 16'h00FF, 4'h0, 1'b0);
        chk(acc, 32'h0000_00FF);
        op(AAD_OP_ADD_MEM, 16'hFFFF, 4'h0, 1'b0);
        chk({acc[30:0], carry_flag}, 32'h0000_01FD);
        op(AAD_OP_ADD_MEM, 16'h0001, 4'h0, 1'b1);
        chk(carry_flag, 32'h1);
        op(AAD_OP_ADD_SHORT, 16'h0001, 4'h0, 1'b0);
        chk({acc[30:0], carry_flag}, 32'h0002_01FE);
        op(AAD_OP_ADD_MEM, 16'hFFFF, 4'h0, 1'b1);
        chk({acc[30:0], carry_flag}, 32'h0000_01FF);
    endtask
    task automatic t_shift_sat();
        rst();
        sign_extend_mode_bit = 1'b0;
        op(AAD_OP_ADD_MEM, 16'h8001, 4'h4, 1'b0);
        chk(acc, 32'h0008_0010);
        sign_extend_mode_bit = 1'b1;
        op(AAD_OP_ADD_MEM, 16'h8001, 4'h4, 1'b0);
        chk(acc, 32'h0000_0020);
        rst();
        sign_extend_mode_bit = 1'b0;
        op(AAD_OP_ADD_MEM, 16'h7FFF, 4'h0, 1'b1);
        op(AAD_OP_ADD_MEM, 16'hFFFF, 4'h0, 1'b0);
        saturate_mode_bit = 1'b1;
        op(AAD_OP_ADD_SHORT, 16'h0001, 4'h0, 1'b0);
        chk(acc, AAD_ACC_MOST_POS);
        chk(overflow_flag, 32'h1);
        saturate_mode_bit = 1'b0;
        op(AAD_OP_ADD_SHORT, 16'h0001, 4'h0, 1'b0);
        chk(acc, AAD_ACC_MOST_NEG);
    endtask
    task automatic t_ind();
        aad_cmd_s c;
        rst();
        aux_init_we = 1'b1;
        aux_init_value = 16'h0010;
        @(posedge core_clk) #1 aux_init_sel = 3'h4;
        aux_init_value = 16'h0302;
        @(posedge core_clk) #1 aux_init_we = 1'b0;
        c = '0;
        c.op = AAD_OP_ADD_MEM;
        c.indirect = 1'b1;
        c.load_next = 1'b1;
        c.next_aux_register = 3'h4;
        run(c, 16'h0002);
        chk(mem_addr, 32'h0302);
        c.post_inc = 1'b1;
        c.next_aux_register = 3'h0;
        run(c, 16'h0002);
        chk({aux_register_four, 13'h0, aux_pointer_select}, 32'h0303_0000);
        chk({acc[30:0], carry_flag}, 32'h0000_0008);
    endtask
    task automatic t_cost();
        // ROM/DUAL_ACCESS_RAM, ROM/ext, ext/DUAL_ACCESS_RAM, ext/ext, same SINGLE_ACCESS_RAM, repeats, 2p, split SINGLE_ACCESS_RAM
        aad_loc_e pl[9] = '{AAD_LOC_ROM, AAD_LOC_ROM, AAD_LOC_EXT, AAD_LOC_EXT,
            AAD_LOC_SINGLE_ACCESS_RAM, AAD_LOC_ROM, AAD_LOC_EXT, AAD_LOC_EXT, AAD_LOC_SINGLE_ACCESS_RAM};
        aad_loc_e ol[9] = '{AAD_LOC_DUAL_ACCESS_RAM, AAD_LOC_EXT, AAD_LOC_DUAL_ACCESS_RAM, AAD_LOC_EXT,
            AAD_LOC_SINGLE_ACCESS_RAM, AAD_LOC_EXT, AAD_LOC_EXT, AAD_LOC_DUAL_ACCESS_RAM, AAD_LOC_SINGLE_ACCESS_RAM};
        logic [7:0] ex[9] = '{8'h01, 8'h04, 8'h03, 8'h07, 8'h02, 8'h14, 8'h17, 8'h05,
            8'h01};
        cost.p_wait = 16'h0002;
        cost.d_wait = 16'h0003;
        cost.repeat_n = 16'h0005;
        cost.data_accesses = 4'h1;
        for (int i = 0; i < 9; i++) begin
            cost.prog_loc = pl[i];
            // last case puts the code one 2K block above the operand
            cost.prog_addr = (i == 8) ? 16'h0800 : 16'h0000;
            cost.opnd_loc = ol[i];
            cost.repeat_instruction = (i == 5 || i == 6);
            cost.prog_accesses = (i == 7) ? 4'h2 : 4'h1;
            op(AAD_OP_ADD_MEM, 16'h0001, 4'h0, 1'b0);
            chk(instr_cycles, ex[i]);
            chk(sameblock_conflict, (i == 4));
        end
    endtask
    task automatic ext(input logic w, input logic [15:0] m, input logic nr, input logic [7:0] e);
        @(posedge core_clk) #1 ext_valid = 1'b1;
        ext_write = w;
        ext_wait_states = m;
        ext_next_is_read = nr;
        @(posedge core_clk) #1 ext_valid = 1'b0;
        chk(ext_access_cycles, e);
    endtask
    task automatic t_ext();
        rst();
        ext(1'b1, 16'h0000, 1'b0, 8'h02);
        ext(1'b0, 16'h0000, 1'b0, 8'h01);
        ext(1'b1, 16'h0000, 1'b0, 8'h03);
        ext(1'b1, 16'h0000, 1'b1, 8'h03);
        ext(1'b0, 16'h0002, 1'b0, 8'h03);
        ext(1'b1, 16'h0002, 1'b0, 8'h04);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        t_abs();
        t_carry();
        t_shift_sat();
        t_ind();
        t_cost();
        t_ext();
        print_verdict();
    end
    // whole run is some hundred cycles
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule // test_aad_datapath
bind aad_datapath aad_datapath_chk u_chk (.core_clk, .rst_n, .cmd_valid, .cmd,
    .saturate_mode_bit, .mem_rdata, .acc, .carry_flag, .overflow_flag, .instr_words, .done);
`default_nettype wire

// *** verilog/aad_datapath.sv ***
// accumulator add/abs datapath with cycle cost model
`timescale 1ns/1ps
`default_nettype none
module aad_datapath (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire aad_pkg::aad_cmd_s cmd,
    input wire aad_pkg::aad_cost_s cost,
    input wire logic sign_extend_mode_bit,
    input wire logic saturate_mode_bit,
    input wire logic [2:0] aux_init_sel,
    input wire logic [15:0] aux_init_value,
    input wire logic aux_init_we,
    input wire logic [15:0] mem_rdata,
    input wire logic ext_valid,
    input wire logic ext_write,
    input wire logic [15:0] ext_wait_states,
    input wire logic ext_next_is_read,
    output logic [15:0] mem_addr,
    output logic [31:0] acc,
    output logic carry_flag,
    output logic overflow_flag,
    output logic [2:0] aux_pointer_select,
    output logic [15:0] aux_register_four,
    output logic [15:0] instr_words,
    output logic [15:0] instr_cycles,
    output logic sameblock_conflict,
    output logic [15:0] ext_access_cycles,
    output logic done
);
    import aad_pkg::*;

    logic [31:0] acc_r;
    logic carry_r;
    logic ov_r;
    logic [2:0] arp_r;
    logic [15:0] aux_r [AAD_NUM_AUX];
    logic [15:0] cycles_r;
    logic [15:0] words_r;
    logic conflict_r;
    logic done_r;

    logic [31:0] operand;
    logic [32:0] sum;
    logic [31:0] add_res;
    logic add_ovf;
    logic [31:0] abs_res;
    logic abs_ovf;
    logic [15:0] addr;
    logic [15:0] p_cost;
    logic [15:0] d_cost;
    logic prog_ext;
    logic opnd_ext;
    logic same_block;
    logic [15:0] cyc_nxt;
    logic has_operand;

    // operand address: direct page zero or pointed aux register
    always_comb begin
        if (cmd.indirect) begin
            addr = aux_r[arp_r];
        end else begin
            addr = {9'h000, cmd.dma};
        end
    end
    assign mem_addr = addr;

    // operand alignment
    always_comb begin
        logic [31:0] ext16;
        ext16 = {{16{sign_extend_mode_bit & mem_rdata[15]}}, mem_rdata};
        if (cmd.op == AAD_OP_ADD_SHORT) begin
            operand = {24'h000000, cmd.short_imm};
        end else if (cmd.shift16) begin
            operand = {mem_rdata, 16'h0000};
        end else begin
            operand = ext16 << cmd.shift;
        end
    end

    // add with overflow detection and saturation
    always_comb begin
        sum = {1'b0, acc_r} + {1'b0, operand};
        add_ovf = (acc_r[31] == operand[31]) && (sum[31] != acc_r[31]);
        if (add_ovf && saturate_mode_bit) begin
            add_res = acc_r[31] ? AAD_ACC_MOST_NEG : AAD_ACC_MOST_POS;
        end else begin
            add_res = sum[31:0];
        end
    end

    // absolute value
    always_comb begin
        abs_ovf = (acc_r == AAD_ACC_MOST_NEG);
        if (abs_ovf) begin
            abs_res = saturate_mode_bit ? AAD_ACC_MOST_POS : AAD_ACC_MOST_NEG;
        end else if (acc_r[31]) begin
            abs_res = 32'(~acc_r + 32'h0000_0001);
        end else begin
            abs_res = acc_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc_r <= AAD_ACC_RESET;
        end else if (cmd_valid) begin
            acc_r <= (cmd.op == AAD_OP_ABS) ? abs_res : add_res;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            carry_r <= 1'b0;
        end else if (cmd_valid) begin
            if (cmd.op == AAD_OP_ABS) begin
                carry_r <= 1'b0;
            end else if (cmd.op == AAD_OP_ADD_MEM && cmd.shift16) begin
                if (sum[32]) begin
                    carry_r <= 1'b1;
                end
            end else begin
                carry_r <= sum[32];
            end
        end
    end

    // overflow is sticky until reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ov_r <= 1'b0;
        end else if (cmd_valid) begin
            if (cmd.op == AAD_OP_ABS) begin
                ov_r <= ov_r | abs_ovf;
            end else begin
                ov_r <= ov_r | add_ovf;
            end
        end
    end

    // aux registers and pointer; software preload loses only to a post-increment add
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < AAD_NUM_AUX; i++) begin
                aux_r[i] <= AAD_AUX_RESET;
            end
        end else if (cmd_valid && cmd.op == AAD_OP_ADD_MEM && cmd.indirect && cmd.post_inc) begin
            aux_r[arp_r] <= 16'(aux_r[arp_r] + 16'h0001);
        end else if (aux_init_we) begin
            aux_r[aux_init_sel] <= aux_init_value;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arp_r <= 3'h0;
        end else if (cmd_valid && cmd.op == AAD_OP_ADD_MEM && cmd.indirect && cmd.load_next) begin
            arp_r <= cmd.next_aux_register;
        end
    end

    // cycle cost model
    always_comb begin
        has_operand = (cmd.op == AAD_OP_ADD_MEM);
        prog_ext = (cost.prog_loc == AAD_LOC_EXT);
        opnd_ext = has_operand && (cost.opnd_loc == AAD_LOC_EXT);
        // only one access per 2K block per cycle
        same_block = has_operand && cost.prog_loc == AAD_LOC_SINGLE_ACCESS_RAM
            && cost.opnd_loc == AAD_LOC_SINGLE_ACCESS_RAM
            && cost.prog_addr[15:AAD_SINGLE_ACCESS_RAM_BLOCK_LOG2]
               == addr[15:AAD_SINGLE_ACCESS_RAM_BLOCK_LOG2];
        p_cost = prog_ext ? 16'(cost.p_wait * cost.prog_accesses) : 16'h0000;
        d_cost = opnd_ext ? 16'(cost.d_wait * cost.data_accesses) : 16'h0000;
        if (cost.repeat_instruction) begin
            cyc_nxt = 16'(cost.repeat_n + p_cost
                + 16'(d_cost * cost.repeat_n));
            if ((prog_ext && opnd_ext) || same_block) begin
                cyc_nxt = 16'(cyc_nxt + 16'h0001);
            end
        end else begin
            cyc_nxt = 16'(16'h0001 + p_cost + d_cost);
            if ((prog_ext && opnd_ext) || same_block) begin
                cyc_nxt = 16'(cyc_nxt + 16'h0001);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cycles_r <= 16'h0000;
            words_r <= 16'h0000;
            conflict_r <= 1'b0;
        end else if (cmd_valid) begin
            cycles_r <= cyc_nxt;
            words_r <= AAD_WORDS_ONE;
            conflict_r <= same_block;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= cmd_valid;
        end
    end

    aad_ext_timer u_ext_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .acc_valid(ext_valid),
        .acc_write(ext_write),
        .wait_states(ext_wait_states),
        .next_is_read(ext_next_is_read),
        .access_cycles(ext_access_cycles)
    );

    assign acc = acc_r;
    assign carry_flag = carry_r;
    assign overflow_flag = ov_r;
    assign aux_pointer_select = arp_r;
    assign aux_register_four = aux_r[4];
    assign instr_words = words_r;
    assign instr_cycles = cycles_r;
    assign sameblock_conflict = conflict_r;
    assign done = done_r;
endmodule // aad_datapath
`default_nettype wire

// *** verilog/aad_ext_timer.sv ***
// external bus access length calculator
`timescale 1ns/1ps
`default_nettype none
module aad_ext_timer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [15:0] wait_states,
    input wire logic next_is_read,
    output logic [15:0] access_cycles
);
    import aad_pkg::*;
    logic prev_read_r;
    logic [15:0] base;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prev_read_r <= 1'b0;
        end else if (acc_valid) begin
            prev_read_r <= !acc_write;
        end
    end
    always_comb begin
        if (!acc_write) begin
            base = AAD_EXT_READ_BASE;
        end else if (wait_states != 16'h0000) begin
            base = AAD_EXT_WRITE_BASE;
        end else if (prev_read_r || next_is_read) begin
            base = AAD_EXT_WRITE_TURN;
        end else begin
            base = AAD_EXT_WRITE_BASE;
        end
    end
    // reads m+1, writes m+2
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            access_cycles <= 16'h0000;
        end else if (acc_valid) begin
            access_cycles <= 16'(base + wait_states);
        end
    end
endmodule // aad_ext_timer
`default_nettype wire

// *** verilog/aad_pkg.sv ***
// package for the accumulator add/abs datapath
// Function
// - abs leaves non-negative accumulator alone, negates a negative one
// - abs always clears the carry flag
// - abs of most negative value: unchanged, or largest positive when saturating
// - abs of most negative value always sets the overflow flag
// - memory add shifts operand left, zero low bits, high bits per sign-extend mode
// - short immediate add: no shift, sign-extend mode ignored
// - add without shift of sixteen sets or clears carry from carry out
// - add with shift of sixteen sets carry on carry, else leaves it
// - indirect: address from pointed aux register, optional increment, optional pointer reload
// - direct, indirect and short immediate adds are one instruction word each
// - single instruction cycles: 1, 1+p, 1+d, or 2+d+p
// - repeated instruction cycles: n, n+p, n+nd, or n+1+p+nd
// - single-access ram is 2K-word blocks, one access per block per cycle
// - external read at least one cycle, external write at least two
// - external write next to an external read takes three cycles when there are no wait states
// - m wait states: read takes m+1 cycles, write m+2 cycles
// - several accesses to one external space multiply its wait cost
package aad_pkg;
    localparam int AAD_ACC_W = 32;
    localparam int AAD_DATA_W = 16;
    localparam int AAD_ADDR_W = 16;
    localparam int AAD_CNT_W = 16;
    localparam int AAD_NUM_AUX = 8;
    localparam int AAD_SHIFT_SIXTEEN = 16;
    localparam int AAD_SINGLE_ACCESS_RAM_BLOCK_LOG2 = 11;
    localparam logic [31:0] AAD_ACC_MOST_NEG = 32'h8000_0000;
    localparam logic [31:0] AAD_ACC_MOST_POS = 32'h7FFF_FFFF;
    localparam logic [31:0] AAD_ACC_RESET = 32'h0000_0000;
    localparam logic [15:0] AAD_AUX_RESET = 16'h0000;
    localparam logic [15:0] AAD_WORDS_ONE = 16'h0001;
    localparam logic [15:0] AAD_EXT_READ_BASE = 16'h0001;
    localparam logic [15:0] AAD_EXT_WRITE_BASE = 16'h0002;
    localparam logic [15:0] AAD_EXT_WRITE_TURN = 16'h0003;

    typedef enum logic [1:0] {AAD_OP_ABS, AAD_OP_ADD_MEM, AAD_OP_ADD_SHORT} aad_op_e;
    typedef enum logic [1:0] {AAD_LOC_ROM, AAD_LOC_DUAL_ACCESS_RAM, AAD_LOC_SINGLE_ACCESS_RAM, AAD_LOC_EXT} aad_loc_e;

    typedef struct packed {
        aad_op_e op;
        logic indirect;
        logic shift16;
        logic [3:0] shift;
        logic post_inc;
        logic load_next;
        logic [2:0] next_aux_register;
        logic [6:0] dma;
        logic [7:0] short_imm;
    } aad_cmd_s;

    typedef struct packed {
        aad_loc_e prog_loc;
        aad_loc_e opnd_loc;
        logic [15:0] prog_addr;
        logic repeat_instruction;
        logic [15:0] repeat_n;
        logic [15:0] p_wait;
        logic [15:0] d_wait;
        logic [3:0] prog_accesses;
        logic [3:0] data_accesses;
    } aad_cost_s;
endpackage
